// ### txcp_pkg.sv
// Package: register map, fields, reset values and cell constants for the transmit cell processor
package txcp_pkg;
  localparam logic [7:0] cfg_one_addr = 8'h80;
  localparam logic [7:0] irq_status_addr = 8'h83;
  localparam logic [7:0] irq_mask_addr = 8'h86;
  localparam logic [7:0] cfg_two_addr = 8'h87;
  localparam logic [7:0] cfg_one_reset = 8'h04;
  localparam logic [7:0] cfg_one_wmask = 8'hcf;
  localparam int fld_flush = 0;
  localparam int fld_scr_dis = 1;
  localparam int fld_coset = 2;
  localparam int fld_hcs_n = 3;
  localparam int fld_thresh = 6;
  localparam int fld_parity = 7;
  localparam int fld_inv = 0;
  localparam int ev_parity = 0;
  localparam int ev_overflow = 1;
  localparam int ev_flush_drop = 2;
  localparam logic [7:0] coset_value = 8'h55;
  localparam int cell_words = 27;
  localparam int hcs_word = 2;
  localparam int word_full = 24;
  localparam int word_near = 19;
  localparam int fifo_cells = 4;
  typedef struct packed {
    logic parity;
    logic scr_dis;
    logic coset;
    logic hcs_n;
    logic thresh;
    logic inv;
  } cfg_s;
  typedef struct packed {
    logic valid;
    logic idle;
    logic [15:0] data;
  } out_word_s;
endpackage

// ### txcp_scrambler.sv
// Self-synchronous x^43+1 payload scrambler for 16-bit words
`timescale 1ns/1ps
module txcp_scrambler (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic bypass,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  logic [42:0] hist_q;
  logic [15:0] scr;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      scr[15 - i] = din[15 - i] ^ hist_q[42 - i];
    end
  end
  assign dout = bypass ? din : scr;
  // History only advances on scrambled words so a later re-enable stays in step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hist_q <= '0;
    end else if (en && !bypass) begin
      hist_q <= {hist_q[26:0], scr};
    end
  end
endmodule

// ### txcp_cell_config.sv
// Transmit cell processor: config registers, 4-cell FIFO, header check and idle cell insertion
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module txcp_cell_config #(
  parameter int cells = txcp_pkg::fifo_cells
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic write_enable,
  input wire logic start_of_cell,
  input wire logic [15:0] write_data_bus,
  input wire logic write_parity,
  output logic cell_space_available,
  input wire logic tx_ready,
  output txcp_pkg::out_word_s tx_word,
  output logic irq
);
  localparam int depth = cells * txcp_pkg::cell_words;
  localparam int aw = $clog2(depth + 1);
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_cell = 2'b01,
    st_idle_cell = 2'b10
  } tx_e;

  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[7] ^ d[i]) ? ((r << 1) ^ 8'h07) : (r << 1);
    end
    return r;
  endfunction

  // Synchronise pins from the ATM layer
  logic [1:0] we_s, soc_s, par_s;
  logic [15:0] dat_s0, dat_s1;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      we_s <= '0;
      soc_s <= '0;
      par_s <= '0;
      dat_s0 <= '0;
      dat_s1 <= '0;
    end else begin
      we_s <= {we_s[0], write_enable};
      soc_s <= {soc_s[0], start_of_cell};
      par_s <= {par_s[0], write_parity};
      dat_s0 <= write_data_bus;
      dat_s1 <= dat_s0;
    end
  end
  logic we, soc, par;
  assign we = we_s[1];
  assign soc = soc_s[1];
  assign par = par_s[1];

  logic [7:0] cfg1_q;
  logic cfg2_inv_q;
  logic [2:0] status_q, mask_q;
  txcp_pkg::cfg_s cfg;
  assign cfg.parity = cfg1_q[txcp_pkg::fld_parity];
  assign cfg.scr_dis = cfg1_q[txcp_pkg::fld_scr_dis];
  assign cfg.coset = cfg1_q[txcp_pkg::fld_coset];
  assign cfg.hcs_n = cfg1_q[txcp_pkg::fld_hcs_n];
  assign cfg.thresh = cfg1_q[txcp_pkg::fld_thresh];
  assign cfg.inv = cfg2_inv_q;
  logic flush;
  assign flush = cfg1_q[txcp_pkg::fld_flush];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg1_q <= txcp_pkg::cfg_one_reset;
      cfg2_inv_q <= 1'b0;
      mask_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == txcp_pkg::cfg_one_addr) cfg1_q <= reg_wdata & txcp_pkg::cfg_one_wmask;
      if (reg_addr == txcp_pkg::cfg_two_addr) cfg2_inv_q <= reg_wdata[txcp_pkg::fld_inv];
      if (reg_addr == txcp_pkg::irq_mask_addr) mask_q <= reg_wdata[2:0];
    end
  end

  // FIFO storage and write side
  logic [15:0] mem [depth];
  logic [aw-1:0] wr_ptr_q, rd_ptr_q, cells_q;
  logic [4:0] wword_q;
  logic full_cells, wr_ok, cell_done, rd_done;
  assign full_cells = (cells_q == aw'(cells));
  // four-cell room
  // Words arriving at a full FIFO are refused, start word included, only until a cell is read out; the rest of that cell is then written
  assign wr_ok = we && !flush && !full_cells;
  assign cell_done = wr_ok && (soc ? 1'b0 : wword_q == 5'(txcp_pkg::cell_words - 1));

  logic par_err;
  assign par_err = we && ((^dat_s1 ^ par) != !cfg.parity);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wword_q <= '0;
      wr_ptr_q <= '0;
    end else if (flush) begin
      wword_q <= '0;
      wr_ptr_q <= rd_ptr_q;
    end else if (wr_ok) begin
      wword_q <= (soc ? 5'h1 : (cell_done ? 5'h0 : wword_q + 5'h1));
      wr_ptr_q <= (wr_ptr_q == aw'(depth - 1)) ? '0 : wr_ptr_q + aw'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (wr_ok && !full_cells) mem[wr_ptr_q] <= dat_s1;
  end

  // Space available drop point
  logic space_q;
  logic [4:0] drop_word;
  assign drop_word = cfg.thresh ? 5'(txcp_pkg::word_full) : 5'(txcp_pkg::word_near);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      space_q <= 1'b1;
    end else if (flush) begin
      space_q <= 1'b1;
    end else if (cells_q >= aw'(cells - 1) && wword_q == drop_word && wr_ok) begin
      space_q <= 1'b0;
    end else if (cells_q < aw'(cells - 1) || (cells_q == aw'(cells - 1) && wword_q == 5'h0)) begin
      space_q <= 1'b1;
    end
  end
  assign cell_space_available = space_q ^ cfg.inv;

  // Read side and cell builder
  tx_e st_q;
  logic [4:0] rword_q;
  logic [7:0] crc_q;
  logic [15:0] raw, body, payload;
  logic [7:0] hcs;
  assign raw = (st_q == st_cell) ? mem[rd_ptr_q] : 16'h0000;
  assign hcs = crc_q ^ (cfg.coset ? txcp_pkg::coset_value : 8'h00);
  always_comb begin
    body = raw;
    if (rword_q == 5'(txcp_pkg::hcs_word) && !cfg.hcs_n) body = {hcs, raw[7:0]};
  end
  logic adv;
  assign adv = tx_ready && st_q != st_idle;
  txcp_scrambler u_scr (
    .clk(clk),
    .nrst(nrst),
    .en(adv && rword_q > 5'(txcp_pkg::hcs_word)),
    .bypass(cfg.scr_dis || rword_q <= 5'(txcp_pkg::hcs_word)),
    .din(body),
    .dout(payload)
  );
  assign rd_done = adv && st_q == st_cell && rword_q == 5'(txcp_pkg::cell_words - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= st_idle;
      rword_q <= '0;
      rd_ptr_q <= '0;
      crc_q <= '0;
    end else if (flush && st_q == st_cell) begin
      st_q <= st_idle;
      rword_q <= '0;
      rd_ptr_q <= wr_ptr_q;
    end else begin
      unique case (st_q)
        st_idle: begin
          st_q <= (cells_q != '0 && !flush) ? st_cell : st_idle_cell;
          rword_q <= '0;
          crc_q <= '0;
        end
        st_cell, st_idle_cell: begin
          if (adv) begin
            if (rword_q < 5'(txcp_pkg::hcs_word)) crc_q <= crc8_step(crc8_step(crc_q, body[15:8]), body[7:0]);
            if (st_q == st_cell) rd_ptr_q <= (rd_ptr_q == aw'(depth - 1)) ? '0 : rd_ptr_q + aw'(1);
            rword_q <= (rword_q == 5'(txcp_pkg::cell_words - 1)) ? 5'h0 : rword_q + 5'h1;
            if (rword_q == 5'(txcp_pkg::cell_words - 1)) st_q <= st_idle;
          end
        end
        default: st_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cells_q <= '0;
    end else if (flush) begin
      cells_q <= '0;
    end else begin
      cells_q <= cells_q + aw'(cell_done && !full_cells) - aw'(rd_done);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_word <= '0;
    end else begin
      tx_word.valid <= adv;
      tx_word.idle <= st_q == st_idle_cell;
      tx_word.data <= payload;
    end
  end

  // sticky parity, overflow and flush-drop flags, set beats read clear
  logic [2:0] ev;
  logic rd_stat;
  assign ev[txcp_pkg::ev_parity] = par_err;
  assign ev[txcp_pkg::ev_overflow] = we && !flush && full_cells && wword_q == 5'h0;
  assign ev[txcp_pkg::ev_flush_drop] = we && flush;
  assign rd_stat = reg_rd && reg_addr == txcp_pkg::irq_status_addr;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      status_q <= (rd_stat ? 3'h0 : status_q) | ev;
    end
  end
  assign irq = |(status_q & mask_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        txcp_pkg::cfg_one_addr: reg_rdata <= cfg1_q;
        txcp_pkg::cfg_two_addr: reg_rdata <= {7'h0, cfg2_inv_q};
        txcp_pkg::irq_status_addr: reg_rdata <= {5'h0, status_q};
        txcp_pkg::irq_mask_addr: reg_rdata <= {5'h0, mask_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  flush_empty_a: assert property (@(posedge clk) disable iff (!nrst) flush |=> cells_q == '0)
    else $error("fifo not empty during flush");
  idle_after_flush_a: assert property (@(posedge clk) disable iff (!nrst)
    flush && st_q == st_idle |=> st_q == st_idle_cell)
    else $error("no idle cell after flush");
  parity_sticky_a: assert property (@(posedge clk) disable iff (!nrst) par_err |=> status_q[0])
    else $error("parity flag not set");
  space_invert_a: assert property (@(posedge clk) disable iff (!nrst)
    cell_space_available == (space_q ^ cfg2_inv_q))
    else $error("space polarity wrong");
  reset_cfg_a: assert property (@(posedge clk) $rose(nrst) |-> cfg1_q == 8'h04)
    else $error("config reset value wrong");
  depth_bound_a: assert property (@(posedge clk) disable iff (!nrst) cells_q <= aw'(cells))
    else $error("fifo over four cells");
  flush_word_a: assert property (@(posedge clk) disable iff (!nrst) flush |=> wword_q == 5'h0)
    else $error("partial cell kept");
  coset_a: assert property (@(posedge clk) disable iff (!nrst) cfg.coset |-> hcs == (crc_q ^ 8'h55))
    else $error("coset not added");
  cover_flush_c: cover property (@(posedge clk) disable iff (!nrst) $fell(flush));
  cover_full_c: cover property (@(posedge clk) disable iff (!nrst) full_cells);
  cover_cell_c: cover property (@(posedge clk) disable iff (!nrst) rd_done);
endmodule

// ### atm_layer_model.sv
// ATM layer model that writes 27-word cells with parity
`timescale 1ns/1ps
module atm_layer_model (
  input wire logic clk,
  input wire logic par_even,
  output logic write_enable,
  output logic start_of_cell,
  output logic [15:0] write_data_bus,
  output logic write_parity
);
  initial begin
    write_enable = 1'b0;
    start_of_cell = 1'b0;
    write_data_bus = 16'h0000;
    write_parity = 1'b0;
  end
  task automatic send_cell(input logic [15:0] base, input logic bad);
    logic [15:0] d;
    for (int i = 0; i < 27; i++) begin
      d = base + 16'(i);
      @(posedge clk);
      write_enable <= 1'b1;
      start_of_cell <= (i == 0);
      write_data_bus <= d;
      write_parity <= (par_even ? ^d : ~^d) ^ (bad && i == 5);
    end
    @(posedge clk);
    write_enable <= 1'b0;
    start_of_cell <= 1'b0;
    // Idle bus shows no stale word
    write_data_bus <= ~d;
    write_parity <= ~write_parity;
  endtask
endmodule

// ### atm_transmit_cell_config_tb.sv
// Testbench for the transmit cell processor configuration
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module atm_transmit_cell_config_tb;
  logic clk, nrst, reg_wr, reg_rd, tx_ready, par_even, irq, space;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic write_enable, start_of_cell, write_parity;
  logic [15:0] write_data_bus;
  logic [15:0] c [27];
  logic [15:0] k [27];
  txcp_pkg::out_word_s tx_word;
  int err_total = 0;
  int checks_done = 0;
  txcp_cell_config DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_enable(write_enable), .start_of_cell(start_of_cell),
    .write_data_bus(write_data_bus), .write_parity(write_parity), .cell_space_available(space),
    .tx_ready(tx_ready), .tx_word(tx_word), .irq(irq));
  atm_layer_model atm (.clk(clk), .par_even(par_even), .write_enable(write_enable),
    .start_of_cell(start_of_cell), .write_data_bus(write_data_bus), .write_parity(write_parity));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cfg(input logic [7:0] d);
    wr(txcp_pkg::cfg_one_addr, d & 8'hcf);
    par_even = d[txcp_pkg::fld_parity];
  endtask
  task automatic get_cell();
    int i, n;
    i = 0;
    n = 0;
    while (i < 27 && n < 3000) begin
      @(posedge clk);
      #1 n++;
      if (tx_word.valid === 1'b1 && tx_word.idle === 1'b0) begin
        c[i] = tx_word.data;
        i++;
      end
    end
    `CHK("cell words", 1, i == 27)
  endtask
  task automatic xfer(input logic [15:0] b);
    fork
      atm.send_cell(b, 1'b0);
      get_cell();
    join
  endtask
  task automatic t_regs();
    rd(txcp_pkg::cfg_one_addr, v);
    `CHK("cfg reset", 8'h04, v)
    rd(8'h55, v);
    `CHK("unmapped", 8'h00, v)
    cfg(8'hce);
    rd(txcp_pkg::cfg_one_addr, v);
    `CHK("cfg rw", 8'hce, v)
  endtask
  task automatic t_payload();
    int diff;
    diff = 0;
    cfg(8'h0e);
    xfer(16'h1200);
    for (int i = 0; i < 27; i++) `CHK("clear word", 16'h1200 + 16'(i), c[i])
    cfg(8'h04);
    xfer(16'h1200);
    for (int i = 3; i < 27; i++) diff += (c[i] != 16'h1200 + 16'(i));
    `CHK("scrambled", 1'b1, diff != 0)
  endtask
  task automatic t_coset();
    cfg(8'h02);
    xfer(16'h3400);
    k = c;
    cfg(8'h06);
    xfer(16'h3400);
    `CHK("coset", txcp_pkg::coset_value, c[2][15:8] ^ k[2][15:8])
    `CHK("coset low byte", k[2][7:0], c[2][7:0])
  endtask
  task automatic t_parity();
    cfg(8'h86);
    rd(txcp_pkg::irq_status_addr, v);
    wr(txcp_pkg::irq_mask_addr, 8'h01);
    xfer(16'h5600);
    rd(txcp_pkg::irq_status_addr, v);
    `CHK("good parity", 1'b0, v[txcp_pkg::ev_parity])
    fork
      atm.send_cell(16'h5700, 1'b1);
      get_cell();
    join
    `CHK("irq set", 1'b1, irq)
    rd(txcp_pkg::irq_status_addr, v);
    `CHK("parity flag", 1'b1, v[txcp_pkg::ev_parity])
    rd(txcp_pkg::irq_status_addr, v);
    `CHK("flag cleared", 8'h00, v)
    `CHK("irq clear", 1'b0, irq)
    wr(txcp_pkg::irq_mask_addr, 8'h00);
  endtask
  task automatic t_space(input logic thr);
    int idle_ok;
    tx_ready <= 1'b0;
    cfg({1'b0, thr, 6'h04});
    for (int j = 0; j < 3; j++) atm.send_cell(16'h7000, 1'b0);
    repeat (4) @(posedge clk);
    `CHK("space three", 1'b1, space)
    fork
      atm.send_cell(16'h7000, 1'b0);
      begin
        repeat ((thr ? txcp_pkg::word_full : txcp_pkg::word_near) + 3) @(posedge clk);
        #1 `CHK("space before drop", 1'b1, space)
        @(posedge clk);
        #1 `CHK("space after drop", 1'b0, space)
      end
    join
    repeat (4) @(posedge clk);
    `CHK("space four", 1'b0, space)
    rd(txcp_pkg::irq_status_addr, v);
    atm.send_cell(16'h7100, 1'b0);
    rd(txcp_pkg::irq_status_addr, v);
    `CHK("overflow", 1'b1, v[txcp_pkg::ev_overflow])
    wr(txcp_pkg::cfg_two_addr, 8'h01);
    #1 `CHK("inverted", 1'b1, space)
    wr(txcp_pkg::cfg_two_addr, 8'h00);
    cfg({1'b0, thr, 6'h05});
    repeat (4) @(posedge clk);
    `CHK("flushed space", 1'b1, space)
    fork
      atm.send_cell(16'h7200, 1'b0);
      #400 tx_ready <= 1'b1;
    join
    rd(txcp_pkg::irq_status_addr, v);
    `CHK("flush drop", 1'b1, v[txcp_pkg::ev_flush_drop])
    idle_ok = 1;
    repeat (100) begin
      @(posedge clk);
      #1 if (tx_word.valid === 1'b1 && tx_word.idle !== 1'b1) idle_ok = 0;
    end
    `CHK("idle only", 1, idle_ok)
    cfg({1'b0, thr, 6'h04});
    xfer(16'h7300);
    `CHK("cell start", 16'h7300, c[0])
  endtask
  task automatic test_done();
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tx_ready = 1'b1;
    par_even = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_payload();
    t_coset();
    t_parity();
    t_space(1'b1);
    t_space(1'b0);
    test_done();
  end
  initial begin
    #3000000;
    err_total++;
    test_done();
  end
endmodule
